// File: design/cas_pkg.sv
// Package with addresses, field positions, reset values and carriers of the counter array control
package cas_pkg;

  localparam logic [7:0] CTRL_ADDR       = 8'hD8;
  localparam logic [7:0] MODE_ADDR       = 8'hD9;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h40;

  localparam int         CTRL_OVF_BIT    = 7;
  localparam int         CTRL_RUN_BIT    = 6;
  localparam int         MODE_IDLE_BIT   = 7;
  localparam int         MODE_WATCHDOG_ENABLE_BIT   = 6;
  localparam int         MODE_WATCHDOG_LOCK_BIT  = 5;
  localparam int         MODE_TB_LSB     = 1;
  localparam int         MODE_OVFIE_BIT  = 0;
  localparam int         MOD_COUNT       = 3;
  localparam int         WDT_MODULE      = 2;

  localparam logic [2:0] TB_DIV12        = 3'h0;
  localparam logic [2:0] TB_DIV4         = 3'h1;
  localparam logic [2:0] TB_TIMER0       = 3'h2;
  localparam logic [2:0] TB_EXT_FALL     = 3'h3;
  localparam logic [2:0] TB_SYSCLK       = 3'h4;
  localparam logic [2:0] TB_EXT_DIV8     = 3'h5;

  localparam logic [3:0] DIV12_LAST      = 4'hB;
  localparam logic [3:0] DIV4_LAST       = 4'h3;
  localparam logic [3:0] DIV8_LAST       = 4'h7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } cas_sfr_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wdata;
    logic       wr;
  } cas_bit_req_t;

endpackage : cas_pkg

// File: design/cas_timebase.sv
// Timebase tick generator that picks the counter increment source
`timescale 1ns/10ps
module cas_timebase (
  input  wire logic       sys_clk,
  input  wire logic       rst_sync_b,
  input  wire logic [2:0] tb_sel,
  input  wire logic       timer0_ovf,
  input  wire logic       ext_count_in,
  output logic            tick
);

  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [3:0] ext_div_reg;
  logic [3:0] ext_div_next;
  logic       ext_prev_reg;
  logic       ext_fall;
  logic       ext_rise;
  logic       div12_hit;
  logic       div4_hit;
  logic       ext8_hit;

  assign ext_fall  = ext_prev_reg && !ext_count_in;
  assign ext_rise  = !ext_prev_reg && ext_count_in;
  assign div12_hit = (div_reg == cas_pkg::DIV12_LAST);
  assign div4_hit  = (div_reg[1:0] == cas_pkg::DIV4_LAST[1:0]);
  assign ext8_hit  = ext_rise && (ext_div_reg == cas_pkg::DIV8_LAST);

  always_comb begin
    div_next     = div12_hit ? 4'h0 : div_reg + 4'h1;
    ext_div_next = ext_div_reg;
    if (ext_rise) begin
      ext_div_next = ext8_hit ? 4'h0 : ext_div_reg + 4'h1;
    end
    case (tb_sel)  // [R10]
      cas_pkg::TB_DIV12:    tick = div12_hit;
      cas_pkg::TB_DIV4:     tick = div4_hit;
      cas_pkg::TB_TIMER0:   tick = timer0_ovf;
      cas_pkg::TB_EXT_FALL: tick = ext_fall;
      cas_pkg::TB_SYSCLK:   tick = 1'b1;
      cas_pkg::TB_EXT_DIV8: tick = ext8_hit;
      default:              tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_reg      <= 4'h0;
      ext_div_reg  <= 4'h0;
      ext_prev_reg <= 1'b0;
    end else begin
      div_reg      <= div_next;
      ext_div_reg  <= ext_div_next;
      ext_prev_reg <= ext_count_in;
    end
  end

  a_sysclk_tick : assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
    tb_sel == cas_pkg::TB_SYSCLK |-> tick)  // [R10]
    else $error("System clock timebase did not tick");
  a_reserved_quiet : assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
    tb_sel[2:1] == 2'b11 |-> !tick)  // [R10]
    else $error("Reserved timebase produced a tick");

endmodule : cas_timebase

// File: design/cas_ctrl_status.sv
// Control and status registers of the programmable counter array
`timescale 1ns/10ps
// Overview of operation
// [R1] A 16-bit counter wrap from FFFF to 0000 sets the overflow flag; only software clears it.
// [R2] With the overflow interrupt enabled, a set overflow flag raises the shared interrupt request.
// [R3] Each module 0..2 sets its own match flag on a compare match or capture.
// [R4] With a module's interrupt enabled, its set match flag raises the shared interrupt request.
// [R5] Hardware never clears a match flag; software clears it after service.
// [R6] Control bit 6 stops the counter at 0 and lets it count at 1; the code keeps it counting at 0 while the watchdog is enabled.
// [R7] Control bits 5 to 3 read as zero and ignore writes.
// [R8] The control register sits at D8 and each bit is also reachable by bit address.
// [R9] A flag write loads the written value, but a coincident hardware set wins over a clear.
// [R10] The timebase field picks clock/12, clock/4, timer 0, external falls, clock or external/8.
// [R11] The overflow interrupt enable bit masks the overflow request at 0 and passes it at 1.
// [R12] With the watchdog enabled, module 2 works as the watchdog timer.
// [R13] With the watchdog enabled, writing 1 to the module 2 flag forces a watchdog reset at once.
module cas_ctrl_status (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire cas_pkg::cas_sfr_req_t sfr_req,
  input  wire cas_pkg::cas_bit_req_t bit_req,
  output logic [7:0]                sfr_rdata,
  output logic                      bit_rdata,
  input  wire logic                 counter_wrap,
  input  wire logic [2:0]           module_event,
  input  wire logic [2:0]           module_irq_en,
  input  wire logic                 cpu_idle,
  input  wire logic                 timer0_ovf,
  input  wire logic                 ext_count_in,
  output logic                      count_tick,
  output logic                      counter_running,
  output logic                      irq_req,
  output logic                      watchdog_mode,
  output logic                      watchdog_reset
);

  logic       rst_meta_reg;
  logic       rst_sync_b;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       bit_rdata_reg;
  logic       bit_rdata_next;
  logic       tick_reg;
  logic       tick_next;
  logic       running_reg;
  logic       running_next;
  logic       irq_reg;
  logic       irq_next;
  logic       wdt_rst_reg;
  logic       wdt_rst_next;
  logic       byte_wr;
  logic       bit_wr;
  logic       mode_wr;
  logic [7:0] wr_en;
  logic [7:0] wr_val;
  logic [3:0] set_evt;
  logic [3:0] flag_next;
  logic       watchdog_enable;
  logic       watchdog_lock;
  logic       run_eff;
  logic       tb_tick;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  assign watchdog_enable    = mode_reg[cas_pkg::MODE_WATCHDOG_ENABLE_BIT];
  assign watchdog_lock   = mode_reg[cas_pkg::MODE_WATCHDOG_LOCK_BIT];
  assign byte_wr = sfr_req.wr && (sfr_req.addr == cas_pkg::CTRL_ADDR);  // [R8]
  assign bit_wr  = bit_req.wr && (bit_req.addr[7:3] == cas_pkg::CTRL_ADDR[7:3]);  // [R8]
  assign mode_wr = sfr_req.wr && (sfr_req.addr == cas_pkg::MODE_ADDR);
  assign set_evt = {counter_wrap, module_event};  // [R1] [R3]
  // Watchdog forces the counter on; idle suspend stops the counter even then
  assign run_eff = (ctrl_reg[cas_pkg::CTRL_RUN_BIT] || watchdog_enable)
                   && !(mode_reg[cas_pkg::MODE_IDLE_BIT] && cpu_idle);  // [R6]

  cas_timebase u_timebase (
    .sys_clk      (sys_clk),
    .rst_sync_b   (rst_sync_b),
    .tb_sel       (mode_reg[cas_pkg::MODE_TB_LSB +: 3]),
    .timer0_ovf   (timer0_ovf),
    .ext_count_in (ext_count_in),
    .tick         (tb_tick)
  );

  // Per-bit write enables from byte and bit writes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wr_en[i]  = byte_wr || (bit_wr && (bit_req.addr[2:0] == 3'(i)));  // [R8]
      wr_val[i] = byte_wr ? sfr_req.wdata[i] : bit_req.wdata;
    end
  end

  // Sticky flags: write loads, hardware set wins
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      localparam int POS = (g == 3) ? cas_pkg::CTRL_OVF_BIT : g;
      always_comb begin
        flag_next[g] = wr_en[POS] ? wr_val[POS] : ctrl_reg[POS];  // [R9] [R5]
        if (set_evt[g]) begin
          flag_next[g] = 1'b1;  // [R1] [R3] [R9]
        end
      end
    end
  endgenerate

  always_comb begin
    ctrl_next = {flag_next[3],
                 wr_en[cas_pkg::CTRL_RUN_BIT] ? wr_val[cas_pkg::CTRL_RUN_BIT]
                                              : ctrl_reg[cas_pkg::CTRL_RUN_BIT],
                 3'h0,  // [R7]
                 flag_next[2:0]};
    mode_next = mode_reg;
    if (mode_wr) begin
      mode_next[cas_pkg::MODE_OVFIE_BIT] = sfr_req.wdata[cas_pkg::MODE_OVFIE_BIT];
      // Lock is set-only; a set lock also enables the watchdog
      mode_next[cas_pkg::MODE_WATCHDOG_LOCK_BIT] = watchdog_lock || sfr_req.wdata[cas_pkg::MODE_WATCHDOG_LOCK_BIT];
      mode_next[cas_pkg::MODE_WATCHDOG_ENABLE_BIT]  = watchdog_lock || sfr_req.wdata[cas_pkg::MODE_WATCHDOG_ENABLE_BIT]
                                           || sfr_req.wdata[cas_pkg::MODE_WATCHDOG_LOCK_BIT];
      if (!watchdog_enable) begin
        mode_next[cas_pkg::MODE_IDLE_BIT]        = sfr_req.wdata[cas_pkg::MODE_IDLE_BIT];
        mode_next[cas_pkg::MODE_TB_LSB +: 3]     = sfr_req.wdata[cas_pkg::MODE_TB_LSB +: 3];
      end
      mode_next[4] = 1'b0;
    end
  end

  always_comb begin
    case (sfr_req.addr)
      cas_pkg::CTRL_ADDR: rdata_next = ctrl_reg;  // [R7]
      cas_pkg::MODE_ADDR: rdata_next = mode_reg;
      default:            rdata_next = 8'h00;
    endcase
    bit_rdata_next = (bit_req.addr[7:3] == cas_pkg::CTRL_ADDR[7:3])
                     ? ctrl_reg[bit_req.addr[2:0]] : 1'b0;  // [R8]
    tick_next      = tb_tick && run_eff;  // [R6]
    running_next   = run_eff;
    irq_next       = (ctrl_reg[cas_pkg::CTRL_OVF_BIT] && mode_reg[cas_pkg::MODE_OVFIE_BIT])
                     || |(ctrl_reg[2:0] & module_irq_en);  // [R2] [R4] [R11]
    wdt_rst_next   = watchdog_enable && wr_en[cas_pkg::WDT_MODULE] && wr_val[cas_pkg::WDT_MODULE];  // [R13]
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_reg      <= cas_pkg::CTRL_RESET;
      mode_reg      <= cas_pkg::MODE_RESET;
      rdata_reg     <= 8'h00;
      bit_rdata_reg <= 1'b0;
      tick_reg      <= 1'b0;
      running_reg   <= 1'b0;
      irq_reg       <= 1'b0;
      wdt_rst_reg   <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      mode_reg      <= mode_next;
      rdata_reg     <= rdata_next;
      bit_rdata_reg <= bit_rdata_next;
      tick_reg      <= tick_next;
      running_reg   <= running_next;
      irq_reg       <= irq_next;
      wdt_rst_reg   <= wdt_rst_next;
    end
  end

  assign sfr_rdata       = rdata_reg;
  assign bit_rdata       = bit_rdata_reg;
  assign count_tick      = tick_reg;
  assign counter_running = running_reg;
  assign irq_req         = irq_reg;
  assign watchdog_mode   = watchdog_enable;  // [R12]
  assign watchdog_reset  = wdt_rst_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  a_ovf_sets_flag : assert property (counter_wrap |=> ctrl_reg[cas_pkg::CTRL_OVF_BIT])  // [R1]
    else $error("Overflow flag not set after counter wrap");
  a_flag_sticky : assert property (ctrl_reg[2] && !wr_en[2] |=> ctrl_reg[2])  // [R5]
    else $error("Module flag cleared without software write");
  a_set_wins : assert property (module_event[0] && wr_en[0] && !wr_val[0] |=> ctrl_reg[0])  // [R9]
    else $error("Software clear beat hardware set");
  a_ovf_irq : assert property (ctrl_reg[cas_pkg::CTRL_OVF_BIT]
    && mode_reg[cas_pkg::MODE_OVFIE_BIT] |=> irq_req)  // [R2]
    else $error("Overflow interrupt not raised");
  a_ovf_masked : assert property (ctrl_reg[2:0] == 3'h0 && !mode_reg[cas_pkg::MODE_OVFIE_BIT]
    |=> !irq_req)  // [R11]
    else $error("Masked overflow raised interrupt");
  a_mod_irq : assert property (ctrl_reg[1] && module_irq_en[1] |=> irq_req)  // [R4]
    else $error("Module interrupt not raised");
  a_run_gate : assert property (!ctrl_reg[cas_pkg::CTRL_RUN_BIT] && !watchdog_enable |=> !count_tick)  // [R6]
    else $error("Counter ticked while stopped");
  a_unused_zero : assert property (sfr_req.addr == cas_pkg::CTRL_ADDR
    |=> sfr_rdata[5:3] == 3'h0)  // [R7]
    else $error("Unused control bits read nonzero");
  a_bit_read : assert property (bit_req.addr == 8'hDE |=> bit_rdata == $past(ctrl_reg[6]))  // [R8]
    else $error("Bit read of run bit wrong");
  a_wdt_force : assert property (watchdog_enable && byte_wr && sfr_req.wdata[2] |=> watchdog_reset)  // [R13]
    else $error("Watchdog force reset missing");
  a_wdt_lock : assert property (watchdog_lock |=> watchdog_enable && watchdog_mode)  // [R12]
    else $error("Locked watchdog was disabled");

  c_overflow_irq : cover property (counter_wrap ##2 irq_req);
  c_wdt_force    : cover property (watchdog_reset);
  c_set_vs_clear : cover property (module_event[2] && wr_en[2] && !wr_val[2]);

endmodule : cas_ctrl_status

// File: verification/cas_cpu_model.sv
// CPU model that drives byte and bit accesses on the register bus
`timescale 1ns/10ps
module cas_cpu_model (
  input  wire logic             sys_clk,
  output cas_pkg::cas_sfr_req_t sfr_req,
  output cas_pkg::cas_bit_req_t bit_req,
  input  wire logic [7:0]       sfr_rdata,
  input  wire logic             bit_rdata
);
  initial begin
    sfr_req = '0;
    bit_req = '0;
  end
  // Byte write, held until the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= '{a, d, 1'b1};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
  endtask : wr
  // Read data is registered, so it is taken two cycles after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_req.addr <= a;
    repeat (2) @(posedge sys_clk);
    d = sfr_rdata;
  endtask : rd
  task automatic bwr(input logic [7:0] a, input logic d);
    @(posedge sys_clk);
    bit_req <= '{a, d, 1'b1};
    @(posedge sys_clk);
    bit_req.wr <= 1'b0;
  endtask : bwr
  task automatic brd(input logic [7:0] a, output logic d);
    @(posedge sys_clk);
    bit_req.addr <= a;
    repeat (2) @(posedge sys_clk);
    d = bit_rdata;
  endtask : brd
endmodule : cas_cpu_model

// File: verification/test_counter_array_control_status.sv
// Self-checking testbench of the counter array control and status block
`timescale 1ns/10ps
module test_counter_array_control_status;
  logic                  sys_clk, rst_b, counter_wrap, cpu_idle;
  logic                  timer0_ovf = 1'b0;
  logic                  ext_count_in = 1'b0;
  logic [2:0]            module_event, module_irq_en;
  logic [1:0]            ph = 2'h0;
  cas_pkg::cas_sfr_req_t sfr_req;
  cas_pkg::cas_bit_req_t bit_req;
  logic [7:0]            sfr_rdata;
  logic                  bit_rdata, count_tick, counter_running;
  logic                  irq_req, watchdog_mode, watchdog_reset;
  int                    fails, checks_done;
  int                    ticks = 0;

  cas_ctrl_status dut (.sys_clk, .rst_b, .sfr_req, .bit_req, .sfr_rdata, .bit_rdata,
    .counter_wrap, .module_event, .module_irq_en, .cpu_idle, .timer0_ovf, .ext_count_in,
    .count_tick, .counter_running, .irq_req, .watchdog_mode, .watchdog_reset);
  cas_cpu_model cpu (.sys_clk, .sfr_req, .bit_req, .sfr_rdata, .bit_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Periodic count sources: timer 0 pulse and external input, both one per 4 cycles
  always @(posedge sys_clk) begin
    ph <= ph + 2'h1;
    ext_count_in <= ph[1];
    timer0_ovf <= (ph == 2'h3);
    if (count_tick === 1'b1) ticks <= ticks + 1;
  end

  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd(a, v);
    chk(v, e);
  endtask : rdc
  task automatic pulse(input logic w, input logic [2:0] m);
    @(posedge sys_clk);
    counter_wrap <= w;
    module_event <= m;
    @(posedge sys_clk);
    {counter_wrap, module_event} <= 4'h0;
  endtask : pulse

  task automatic t_reset;
    rdc(8'hD8, 8'h00);
    rdc(8'hD9, 8'h40);
    rdc(8'hD7, 8'h00);
    chk({7'h0, watchdog_mode}, 8'h01);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_run;
    cpu.wr(8'hD9, 8'h00);
    cyc(2);
    chk({7'h0, watchdog_mode}, 8'h00);
    cpu.wr(8'hD8, 8'h7F);
    rdc(8'hD8, 8'h47);
    cpu.wr(8'hD8, 8'h40);
    cyc(2);
    chk({7'h0, counter_running}, 8'h01);
    cpu.wr(8'hD9, 8'h80);
    cpu_idle <= 1'b1;
    cyc(3);
    chk({7'h0, counter_running}, 8'h00);
    cpu_idle <= 1'b0;
    cpu.wr(8'hD8, 8'h00);
    cyc(2);
    chk({7'h0, counter_running}, 8'h00);
    cpu.wr(8'hD9, 8'h00);
    $display("t_run done");
  endtask : t_run
  task automatic t_flags;
    logic [7:0] f;
    for (int i = 0; i < 4; i++) begin
      f = (i == 3) ? 8'h80 : 8'h01 << i;
      pulse(i == 3, f[2:0]);
      cyc(2);
      rdc(8'hD8, f);
      chk({7'h0, irq_req}, 8'h00);
      if (i == 3) cpu.wr(8'hD9, 8'h01);
      else module_irq_en <= f[2:0];
      cyc(3);
      chk({7'h0, irq_req}, 8'h01);
      cyc(20);
      rdc(8'hD8, f);
      cpu.wr(8'hD8, 8'h00);
      cyc(3);
      chk({7'h0, irq_req}, 8'h00);
      module_irq_en <= 3'h0;
    end
    pulse(1'b1, 3'h0);
    cyc(2);
    chk({7'h0, irq_req}, 8'h01);
    cpu.wr(8'hD9, 8'h00);
    fork
      cpu.wr(8'hD8, 8'h00);
      pulse(1'b0, 3'h4);
    join
    rdc(8'hD8, 8'h04);
    cpu.wr(8'hD8, 8'h00);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_bit;
    logic b;
    cpu.bwr(8'hDE, 1'b1);
    cyc(2);
    chk({7'h0, counter_running}, 8'h01);
    cpu.brd(8'hDE, b);
    chk({7'h0, b}, 8'h01);
    cpu.bwr(8'hDB, 1'b1);
    cpu.brd(8'hDB, b);
    chk({7'h0, b}, 8'h00);
    cpu.bwr(8'hDE, 1'b0);
    $display("t_bit done");
  endtask : t_bit
  task automatic t_tb;
    int n0;
    logic [7:0] exp [8] = '{8'h08, 8'h18, 8'h18, 8'h18, 8'h60, 8'h03, 8'h00, 8'h00};
    cpu.wr(8'hD8, 8'h40);
    for (int c = 0; c < 8; c++) begin
      cpu.wr(8'hD9, {4'h0, 3'(c), 1'b0});
      cyc(16);
      n0 = ticks;
      cyc(96);
      chk(8'(ticks - n0), exp[c]);
    end
    cpu.wr(8'hD8, 8'h00);
    $display("t_tb done");
  endtask : t_tb
  task automatic t_wdt;
    int n;
    n = 0;
    cpu.wr(8'hD8, 8'h04);
    repeat (4) @(posedge sys_clk) if (watchdog_reset === 1'b1) n++;
    cpu.wr(8'hD8, 8'h00);
    cpu.wr(8'hD9, 8'h40);
    cyc(2);
    chk({7'h0, watchdog_mode}, 8'h01);
    chk({7'h0, counter_running}, 8'h01);
    cpu.wr(8'hD8, 8'h04);
    repeat (4) @(posedge sys_clk) if (watchdog_reset === 1'b1) n++;
    chk(8'(n), 8'h01);
    cpu.wr(8'hD9, 8'h20);
    cpu.wr(8'hD9, 8'h00);
    rdc(8'hD9, 8'h60);
    $display("t_wdt done");
  endtask : t_wdt

  initial begin
    {rst_b, counter_wrap, cpu_idle} = '0;
    {module_event, module_irq_en} = '0;
    {fails, checks_done} = '0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(3);
    t_reset;
    t_run;
    t_flags;
    t_bit;
    t_tb;
    t_wdt;
    end_sim;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim;
  end
endmodule : test_counter_array_control_status
